// >>> bench/ctmr_assertions.sv
// Purpose: port checks for the compact timer
// Assumes: compare low byte written before high byte
// Notes: control and compare shadows rebuilt from bus writes
`timescale 1ns/1ps
module ctmr_assertions (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // pin and requests
  input wire logic timer_output_pin,
  input wire logic timer_output_oe,
  input wire logic irq_compare_a,
  input wire logic irq_period_p
);
  logic [7:0] c1_q;
  logic [7:0] lo_q;
  logic [15:0] cmp_q;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  // shadows only valid while software keeps the low-then-high order
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      c1_q <= 8'h00;
      lo_q <= 8'h00;
      cmp_q <= 16'h0000;
    end else if (reg_wr) begin
      if (reg_addr == 3'h1) c1_q <= reg_wdata;
      if (reg_addr == 3'h4) lo_q <= reg_wdata;
      if (reg_addr == 3'h5) cmp_q <= {reg_wdata, lo_q};
    end
  end
  ////////////////////////////////////////
  rd_idle_zero_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  mode_read_a: assert property (reg_rd && reg_addr == 3'h1 |=> reg_rdata == c1_q)
    else $error("control byte read back wrong");
  cmp_hi_read_a: assert property (reg_rd && reg_addr == 3'h5 |=> reg_rdata == cmp_q[15:8])
    else $error("compare high byte wrong");
  cmp_lo_pair_a: assert property (reg_rd && reg_addr == 3'h5 ##2 reg_rd && reg_addr == 3'h4
    |=> reg_rdata == cmp_q[7:0]) else $error("compare low byte not from buffer");
  irq_a_pulse_a: assert property (irq_compare_a |=> !irq_compare_a)
    else $error("compare request longer than one cycle");
  irq_p_pulse_a: assert property ($rose(irq_period_p) |=> $fell(irq_period_p))
    else $error("period request longer than one cycle");
  oe_mode_a: assert property (timer_output_oe == !c1_q[6])
    else $error("output enable does not follow mode");
  pin_idle_a: assert property (!timer_output_oe |-> !timer_output_pin)
    else $error("pin active while not driven");
  pin_set_a: assert property (irq_compare_a && c1_q[7:6] == 2'h0 && (c1_q[5] ^ c1_q[4])
    |-> timer_output_pin == (c1_q[5] ^ c1_q[2])) else $error("pin level wrong at match");
  pin_toggle_a: assert property (irq_compare_a && c1_q[7:4] == 4'h3
    |-> timer_output_pin != $past(timer_output_pin)) else $error("pin did not toggle");
endmodule
bind ctmr_core ctmr_assertions u_chk (
  .core_clk(core_clk),
  .sys_rst(sys_rst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .timer_output_pin(timer_output_pin),
  .timer_output_oe(timer_output_oe),
  .irq_compare_a(irq_compare_a),
  .irq_period_p(irq_period_p)
);

// >>> bench/ctmr_ext_src.sv
// Purpose: external event source feeding the count pin
// Assumes: pin already routed to the timer as an input
// Notes: 3 cycles high, 7 low, so rising and falling edges differ in phase
`timescale 1ns/1ps
module ctmr_ext_src (
  // clock and control
  input wire logic core_clk,
  input wire logic run,
  // event pin
  output logic ext_clock_pin
);
  int ph = 0;
  ////////////////////////////////////////
  // routed and set as input before use, so only this source drives it
  initial ext_clock_pin = 1'b0;
  // stands low while run is low; events repeat every 10 cycles while run is high
  always @(posedge core_clk) begin
    ph <= run ? (ph + 1) % 10 : 0;
    ext_clock_pin <= run && ph < 3;
  end
endmodule

// >>> bench/tb_top.sv
// Purpose: self-checking bench for the compact timer
// Assumes: enables and event pin driven by the bench and partner
// Notes: expected intervals and counts derive from clock and compare settings
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic high_clk_en = 1'b0;
  logic sub_clk_en = 1'b0;
  logic sub_auto = 1'b0;
  logic sub_man = 1'b0;
  logic run = 1'b0;
  logic ext_q = 1'b0;
  logic [7:0] reg_rdata;
  logic ext_clock_pin, timer_output_pin, timer_output_oe, irq_compare_a, irq_period_p;
  logic [15:0] lf = 16'hBD46;
  int err_count = 0;
  int cmp_count = 0;
  int sub_ph = 0;
  int since_r = 0;
  int since_f = 0;
  int t, d6, n, k, hi;
  int mul[8] = '{4, 1, 32, 128, 3, 3, 10, 10};
  always #50 core_clk = ~core_clk;
  ctmr_core u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .high_clk_en(high_clk_en), .sub_clk_en(sub_clk_en), .ext_clock_pin(ext_clock_pin),
    .timer_output_pin(timer_output_pin), .timer_output_oe(timer_output_oe),
    .irq_compare_a(irq_compare_a), .irq_period_p(irq_period_p));
  ctmr_ext_src u_ext (.core_clk(core_clk), .run(run), .ext_clock_pin(ext_clock_pin));
  ////////////////////////////////////////
  // high clock enable every other cycle; edge ages track the event pin
  always @(posedge core_clk) begin
    high_clk_en <= ~high_clk_en;
    sub_ph <= (sub_ph + 1) % 3;
    sub_clk_en <= sub_auto ? (sub_ph == 0) : sub_man;
    ext_q <= ext_clock_pin;
    since_r <= (ext_clock_pin && !ext_q) ? 0 : since_r + 1;
    since_f <= (!ext_clock_pin && ext_q) ? 0 : since_f + 1;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic test_done();
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // gap cycle after each strobe so no signal is driven twice in one step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(16'(reg_rdata), 16'(e));
    @(posedge core_clk);
  endtask
  task automatic pulses(input int m);
    repeat (m) begin
      sub_man <= 1'b1;
      @(posedge core_clk);
      sub_man <= 1'b0;
      @(posedge core_clk);
    end
    repeat (2) @(posedge core_clk);
  endtask
  task automatic wait_irq(input bit p, output int m);
    m = 0;
    do begin
      @(posedge core_clk);
      m++;
    end while ((p ? irq_period_p : irq_compare_a) !== 1'b1 && m < 3000);
    if (m >= 3000) begin
      err_count++;
      test_done();
    end
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), 8'h00);
    end
    lf = lfsr(lf);
    k = 200 + int'(lf[5:0]);
    wr(3'h1, 8'h01);
    wr(3'h4, 8'hFF);
    wr(3'h5, 8'hFF);
    wr(3'h0, 8'h48);
    pulses(k);
    rd(3'h3, 8'(k >> 8));
    pulses(3);
    rd(3'h2, 8'(k));
    wr(3'h3, 8'h55);
    wr(3'h0, 8'h40);
    pulses(2);
    rd(3'h3, 8'((k + 3) >> 8));
    rd(3'h2, 8'(k + 3));
    wr(3'h0, 8'h48);
    rd(3'h3, 8'h00);
    rd(3'h2, 8'h00);
    run <= 1'b1;
    sub_auto <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      lf = lfsr(lf);
      n = 2 + int'(lf[2:0]);
      wr(3'h0, 8'h00);
      wr(3'h1, {2'b00, 2'(c % 3 + 1), 1'b0, c[0], 2'b01});
      wr(3'h4, 8'(n));
      wr(3'h5, 8'h00);
      wr(3'h0, {1'b0, 3'(c), 4'h8});
      wait_irq(1'b0, t);
      wait_irq(1'b0, t);
      chk(16'(t), 16'(mul[c] * (n + 1)));
      if (c == 6) d6 = since_r;
      if (c == 7) chk(16'(since_f), 16'(d6));
    end
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h00);
    wr(3'h6, 8'h01);
    wr(3'h0, 8'h18);
    wait_irq(1'b1, t);
    wait_irq(1'b1, t);
    chk(16'(t), 16'h0101);
    wait_irq(1'b0, t);
    wait_irq(1'b0, t);
    chk(16'(t), 16'h0101);
    // duty from compare then from period; window spans exactly one period
    for (int d = 0; d < 2; d++) begin
      wr(3'h0, 8'h00);
      wr(3'h1, {6'b101010, d[0], 1'b0});
      wr(3'h4, d ? 8'h00 : 8'h40);
      wr(3'h5, d ? 8'h03 : 8'h00);
      wr(3'h0, 8'h18);
      repeat (8) @(posedge core_clk);
      hi = 0;
      repeat (d ? 769 : 257) begin
        @(posedge core_clk);
        hi += int'(timer_output_pin);
      end
      chk(16'(hi), d ? 16'h0100 : 16'h0040);
      chk(16'(timer_output_oe), 16'h0001);
    end
    rd(3'h5, 8'h03);
    rd(3'h4, 8'h00);
    wr(3'h4, 8'hAA);
    rd(3'h5, 8'h03);
    rd(3'h4, 8'h00);
    rd(3'h6, 8'h01);
    wr(3'h1, 8'hC0);
    chk(16'(timer_output_oe), 16'h0000);
    chk(16'(timer_output_pin), 16'h0000);
    wr(3'h1, 8'h40);
    chk(16'(timer_output_oe), 16'h0000);
    test_done();
  end
endmodule

// >>> core/ctmr_core.sv
// Purpose: compact timer, 16-bit up counter with two comparators and one output pin
// Assumes: all inputs synchronous to core_clk; slower clocks arrive as enable pulses
// Notes: low bytes of 16-bit registers go through one shared 8-bit holding buffer
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module ctmr_core (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // slower internal clocks as enables
  input wire logic high_clk_en,
  input wire logic sub_clk_en,
  // timer pins
  input wire logic ext_clock_pin,
  output logic timer_output_pin,
  output logic timer_output_oe,
  // interrupt requests
  output logic irq_compare_a,
  output logic irq_period_p
);

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic pause_q;
  logic [2:0] clock_select_field_q;
  logic counter_on_bit_q;
  logic [1:0] op_mode_field_q;
  logic [1:0] pin_action_q;
  logic out_ctrl_q;
  logic out_pol_q;
  logic duty_swap_q;
  logic clear_select_bit_q;
  logic [15:0] compare_a_value_q;
  logic [7:0] period_compare_value_q;
  logic [7:0] hold_buf_q;
  logic [7:0] rdata_q;
  logic [15:0] cnt_q;

  logic wr_c0;
  logic wr_c1;
  logic wr_alo;
  logic wr_ahi;
  logic wr_per;
  logic rd_dhi;
  logic rd_ahi;

  assign wr_c0 = reg_wr && (reg_addr == ctmr_pkg::CTMR_OFS_CTRL0);
  assign wr_c1 = reg_wr && (reg_addr == ctmr_pkg::CTMR_OFS_CTRL1);
  assign wr_alo = reg_wr && (reg_addr == ctmr_pkg::CTMR_OFS_CMPA_LO);
  assign wr_ahi = reg_wr && (reg_addr == ctmr_pkg::CTMR_OFS_CMPA_HI);
  assign wr_per = reg_wr && (reg_addr == ctmr_pkg::CTMR_OFS_PERIOD);
  assign rd_dhi = reg_rd && (reg_addr == ctmr_pkg::CTMR_OFS_CNT_HI);
  assign rd_ahi = reg_rd && (reg_addr == ctmr_pkg::CTMR_OFS_CMPA_HI);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pause_q <= 1'b0;
      clock_select_field_q <= ctmr_pkg::CTMR_CK_SYS4;
      counter_on_bit_q <= 1'b0;
    end else if (wr_c0) begin
      pause_q <= reg_wdata[ctmr_pkg::CTMR_C0_PAUSE];
      clock_select_field_q <= reg_wdata[ctmr_pkg::CTMR_C0_CKSEL_LSB +: 3];
      counter_on_bit_q <= reg_wdata[ctmr_pkg::CTMR_C0_ON];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_mode_field_q <= ctmr_pkg::CTMR_MODE_CMP;
      pin_action_q <= ctmr_pkg::CTMR_IO_NONE;
      out_ctrl_q <= 1'b0;
      out_pol_q <= 1'b0;
      duty_swap_q <= 1'b0;
      clear_select_bit_q <= 1'b0;
    end else if (wr_c1) begin
      op_mode_field_q <= reg_wdata[ctmr_pkg::CTMR_C1_MODE_LSB +: 2];
      pin_action_q <= reg_wdata[ctmr_pkg::CTMR_C1_IO_LSB +: 2];
      out_ctrl_q <= reg_wdata[ctmr_pkg::CTMR_C1_OC];
      out_pol_q <= reg_wdata[ctmr_pkg::CTMR_C1_POL];
      duty_swap_q <= reg_wdata[ctmr_pkg::CTMR_C1_DPX];
      clear_select_bit_q <= reg_wdata[ctmr_pkg::CTMR_C1_CCLR];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      period_compare_value_q <= ctmr_pkg::CTMR_RST_BYTE;
    end else if (wr_per) begin
      period_compare_value_q <= reg_wdata;
    end
  end

  // compare value only moves as a whole word, so the comparator never sees half an update
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      compare_a_value_q <= ctmr_pkg::CTMR_RST_WORD;
    end else if (wr_ahi) begin
      compare_a_value_q <= {reg_wdata, hold_buf_q};
    end
  end

  // one buffer shared by counter and compare pairs; interleaved access corrupts it
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_buf_q <= ctmr_pkg::CTMR_RST_BYTE;
    end else if (wr_alo) begin
      hold_buf_q <= reg_wdata;
    end else if (rd_dhi) begin
      hold_buf_q <= cnt_q[7:0];
    end else if (rd_ahi) begin
      hold_buf_q <= compare_a_value_q[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= ctmr_pkg::CTMR_RST_BYTE;
    end else if (!reg_rd) begin
      rdata_q <= ctmr_pkg::CTMR_RST_BYTE;
    end else begin
      case (reg_addr)
        ctmr_pkg::CTMR_OFS_CTRL0: begin
          rdata_q <= {pause_q, clock_select_field_q, counter_on_bit_q, 3'h0};
        end
        ctmr_pkg::CTMR_OFS_CTRL1: begin
          rdata_q <= {op_mode_field_q, pin_action_q, out_ctrl_q, out_pol_q,
                      duty_swap_q, clear_select_bit_q};
        end
        ctmr_pkg::CTMR_OFS_CNT_LO, ctmr_pkg::CTMR_OFS_CMPA_LO: begin
          rdata_q <= hold_buf_q;
        end
        ctmr_pkg::CTMR_OFS_CNT_HI: begin
          rdata_q <= cnt_q[15:8];
        end
        ctmr_pkg::CTMR_OFS_CMPA_HI: begin
          rdata_q <= compare_a_value_q[15:8];
        end
        ctmr_pkg::CTMR_OFS_PERIOD: begin
          rdata_q <= period_compare_value_q;
        end
        default: begin
          rdata_q <= ctmr_pkg::CTMR_RST_BYTE;
        end
      endcase
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // clock source selection
  logic [1:0] sys_div_q;
  logic [5:0] high_div_q;
  logic ext_prev_q;
  logic on_prev_q;
  logic on_rise;
  logic src_tick;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sys_div_q <= 2'h0;
    end else begin
      sys_div_q <= sys_div_q + 2'h1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      high_div_q <= 6'h00;
    end else if (high_clk_en) begin
      high_div_q <= high_div_q + 6'h01;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_prev_q <= 1'b0;
      on_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_clock_pin;
      on_prev_q <= counter_on_bit_q;
    end
  end

  assign on_rise = counter_on_bit_q && !on_prev_q;

  always_comb begin
    case (clock_select_field_q)
      ctmr_pkg::CTMR_CK_SYS4: begin
        src_tick = (sys_div_q == ctmr_pkg::CTMR_DIV4_LAST);
      end
      ctmr_pkg::CTMR_CK_SYS: begin
        src_tick = 1'b1;
      end
      ctmr_pkg::CTMR_CK_H16: begin
        src_tick = high_clk_en &&
                   ((high_div_q & ctmr_pkg::CTMR_DIV16_MASK) == ctmr_pkg::CTMR_DIV16_LAST);
      end
      ctmr_pkg::CTMR_CK_H64: begin
        src_tick = high_clk_en && (high_div_q == ctmr_pkg::CTMR_DIV64_LAST);
      end
      ctmr_pkg::CTMR_CK_SUB0, ctmr_pkg::CTMR_CK_SUB1: begin
        src_tick = sub_clk_en;
      end
      ctmr_pkg::CTMR_CK_EXT_RISE: begin
        src_tick = ext_clock_pin && !ext_prev_q;
      end
      ctmr_pkg::CTMR_CK_EXT_FALL: begin
        src_tick = !ext_clock_pin && ext_prev_q;
      end
      default: begin
        src_tick = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter and comparators
  logic cnt_tick;
  logic match_a;
  logic match_p;
  logic clr_hit;
  logic cnt_new_q;
  logic is_pwm;
  logic is_cmp;

  assign is_pwm = (op_mode_field_q == ctmr_pkg::CTMR_MODE_PWM);
  assign is_cmp = (op_mode_field_q == ctmr_pkg::CTMR_MODE_CMP);
  assign cnt_tick = src_tick && counter_on_bit_q && !pause_q && !on_rise;
  assign match_a = (cnt_q == compare_a_value_q);
  assign match_p = (cnt_q[15:8] == period_compare_value_q);

  // outside PWM mode, with the clear-select bit off, a zero period disables the P clear and leaves only the overflow wrap
  always_comb begin
    if (is_pwm) begin
      clr_hit = duty_swap_q ? match_a : match_p;
    end else if (clear_select_bit_q) begin
      clr_hit = match_a;
    end else if (period_compare_value_q == ctmr_pkg::CTMR_RST_BYTE) begin
      clr_hit = (cnt_q == ctmr_pkg::CTMR_CNT_TOP);
    end else begin
      clr_hit = match_p;
    end
  end

  // no write path to the count: software can only clear it, through the on-bit rise
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= ctmr_pkg::CTMR_RST_WORD;
    end else if (on_rise) begin
      cnt_q <= ctmr_pkg::CTMR_RST_WORD;
    end else if (cnt_tick) begin
      if (clr_hit) begin
        cnt_q <= ctmr_pkg::CTMR_RST_WORD;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_new_q <= 1'b0;
    end else begin
      cnt_new_q <= cnt_tick;
    end
  end

  // fresh counts only; P fires on entering its band, not for all 256 counts in it
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_compare_a <= 1'b0;
      irq_period_p <= 1'b0;
    end else begin
      irq_compare_a <= cnt_new_q && match_a;
      irq_period_p <= cnt_new_q && match_p &&
                      (cnt_q[7:0] == ctmr_pkg::CTMR_RST_BYTE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output pin
  logic out_q;
  logic pwm_active;

  always_comb begin
    if (duty_swap_q) begin
      pwm_active = (cnt_q[15:8] < period_compare_value_q);
    end else begin
      pwm_active = (cnt_q < compare_a_value_q);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_q <= 1'b0;
    end else if (on_rise) begin
      out_q <= out_ctrl_q;
    end else if (is_cmp) begin
      if (cnt_new_q && match_a) begin
        case (pin_action_q)
          ctmr_pkg::CTMR_IO_LOW: begin
            out_q <= 1'b0;
          end
          ctmr_pkg::CTMR_IO_HIGH: begin
            out_q <= 1'b1;
          end
          ctmr_pkg::CTMR_IO_TOGGLE: begin
            out_q <= !out_q;
          end
          default: begin
            out_q <= out_q;
          end
        endcase
      end
    end else if (is_pwm) begin
      case (pin_action_q)
        ctmr_pkg::CTMR_IO_LOW: begin
          out_q <= out_ctrl_q;
        end
        ctmr_pkg::CTMR_IO_HIGH: begin
          out_q <= pwm_active ? out_ctrl_q : !out_ctrl_q;
        end
        default: begin
          out_q <= !out_ctrl_q;
        end
      endcase
    end else begin
      out_q <= 1'b0;
    end
  end

  // timer and undefined modes keep the pin undriven and low
  assign timer_output_pin = (is_cmp || is_pwm) ? (out_q ^ out_pol_q) : 1'b0;
  assign timer_output_oe = is_cmp || is_pwm;

endmodule

// >>> core/ctmr_pkg.sv
// Purpose: shared constants for the compact timer block
// Assumes: 8-bit register port, registers at indices 0 to 6
// Notes: field positions follow the two control bytes
package ctmr_pkg;

  // register offsets
  localparam logic [2:0] CTMR_OFS_CTRL0 = 3'h0;
  localparam logic [2:0] CTMR_OFS_CTRL1 = 3'h1;
  localparam logic [2:0] CTMR_OFS_CNT_LO = 3'h2;
  localparam logic [2:0] CTMR_OFS_CNT_HI = 3'h3;
  localparam logic [2:0] CTMR_OFS_CMPA_LO = 3'h4;
  localparam logic [2:0] CTMR_OFS_CMPA_HI = 3'h5;
  localparam logic [2:0] CTMR_OFS_PERIOD = 3'h6;

  // control 0 fields
  localparam int CTMR_C0_PAUSE = 7;
  localparam int CTMR_C0_CKSEL_LSB = 4;
  localparam int CTMR_C0_ON = 3;

  // control 1 fields
  localparam int CTMR_C1_MODE_LSB = 6;
  localparam int CTMR_C1_IO_LSB = 4;
  localparam int CTMR_C1_OC = 3;
  localparam int CTMR_C1_POL = 2;
  localparam int CTMR_C1_DPX = 1;
  localparam int CTMR_C1_CCLR = 0;

  // reset values and counter top
  localparam logic [7:0] CTMR_RST_BYTE = 8'h00;
  localparam logic [15:0] CTMR_RST_WORD = 16'h0000;
  localparam logic [15:0] CTMR_CNT_TOP = 16'hFFFF;

  // clock select codes
  localparam logic [2:0] CTMR_CK_SYS4 = 3'h0;
  localparam logic [2:0] CTMR_CK_SYS = 3'h1;
  localparam logic [2:0] CTMR_CK_H16 = 3'h2;
  localparam logic [2:0] CTMR_CK_H64 = 3'h3;
  localparam logic [2:0] CTMR_CK_SUB0 = 3'h4;
  localparam logic [2:0] CTMR_CK_SUB1 = 3'h5;
  localparam logic [2:0] CTMR_CK_EXT_RISE = 3'h6;
  localparam logic [2:0] CTMR_CK_EXT_FALL = 3'h7;

  // divider terminal counts and mask
  localparam logic [1:0] CTMR_DIV4_LAST = 2'h3;
  localparam logic [5:0] CTMR_DIV16_LAST = 6'h0F;
  localparam logic [5:0] CTMR_DIV64_LAST = 6'h3F;
  localparam logic [5:0] CTMR_DIV16_MASK = 6'h0F;

  // operating modes
  localparam logic [1:0] CTMR_MODE_CMP = 2'h0;
  localparam logic [1:0] CTMR_MODE_UNDEF = 2'h1;
  localparam logic [1:0] CTMR_MODE_PWM = 2'h2;
  localparam logic [1:0] CTMR_MODE_TMR = 2'h3;

  // pin action codes
  localparam logic [1:0] CTMR_IO_NONE = 2'h0;
  localparam logic [1:0] CTMR_IO_LOW = 2'h1;
  localparam logic [1:0] CTMR_IO_HIGH = 2'h2;
  localparam logic [1:0] CTMR_IO_TOGGLE = 2'h3;

endpackage
